/* File: common/vrc_pkg.sv */
// package: register address, bit positions and carrier types for reference control
package vrc_pkg;
  localparam logic [7:0] VRC_ADDR = 8'hD1;
  localparam logic [7:0] VRC_RESET = 8'h00;
  localparam int VRC_BIT_BIAS = 1;
  localparam int VRC_BIT_TEMP = 2;
  localparam int VRC_BIT_REF_SEL = 3;
  localparam logic VRC_SRC_PIN = 1'b0;
  localparam logic VRC_SRC_SUPPLY = 1'b1;

  // special-function register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } vrc_sfr_req_t;

  // analog controls toward the reference section
  typedef struct packed {
    logic ref_source_supply;
    logic bias_on;
    logic temp_on;
    logic temp_out_en;
  } vrc_analog_t;

  // stored software bits
  typedef struct packed {
    logic ref_sel;
    logic temp;
    logic bias;
  } vrc_bits_t;
endpackage

/* File: rtl/vrc_reference_control.sv */
// module: reference control register and analog enable logic
//
// Contract
// - source select 0 picks external reference pin, 1 picks supply
// - bias enable reads and acts 1 while ADC, sensor or oscillator enabled
// - software writing 1 to bias enable keeps bias on while held
// - temperature sensor enable 1 powers sensor on, 0 off
// - disabled sensor output to top ADC mux input is high impedance
`timescale 1ns/10ps
`default_nettype none
module vrc_reference_control (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // special-function register bus
  input wire vrc_pkg::vrc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // enables of peripherals that need bias (from other domains)
  input wire logic adc_enable,
  input wire logic osc_enable,
  // analog controls
  output vrc_pkg::vrc_analog_t analog
);
  import vrc_pkg::*;

  // number of outside peripherals that can force the bias on
  localparam int N_PERIPH = 2;

  // everything this block remembers, registered once per clock
  typedef struct packed {
    vrc_bits_t bits;
    logic [7:0] rdata;
    vrc_analog_t ana;
  } vrc_state_t;

  // registered state and its next value
  vrc_state_t state_reg;
  vrc_state_t state_next;

  // peripheral enables after the synchroniser
  logic [N_PERIPH-1:0] periph_sync;
  logic adc_on_sync;
  logic osc_on_sync;

  // bus decode
  logic sel;
  logic wr_hit;

  // field values carried by the bus
  logic ref_sel_wval;
  logic temp_wval;
  logic bias_wval;

  // bias force sources and the bias as it acts
  logic [2:0] force_vec;
  logic bias_forced;
  logic bias_eff;

  // peripheral enables may come from slower logic, so they are synchronised
  vrc_sync #(
    .WIDTH(N_PERIPH)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({adc_enable, osc_enable}),
    .q(periph_sync)
  );

  // two flops cost two cycles of force latency; traded for no metastability
  assign adc_on_sync = periph_sync[1];
  assign osc_on_sync = periph_sync[0];

  // address compare only; reads have no side effects, so no read strobe
  assign sel = (sfr_req.addr == VRC_ADDR);
  assign wr_hit = sel & sfr_req.wr;

  // only defined bits are picked from the bus
  assign ref_sel_wval = sfr_req.wdata[VRC_BIT_REF_SEL];
  assign temp_wval = sfr_req.wdata[VRC_BIT_TEMP];
  assign bias_wval = sfr_req.wdata[VRC_BIT_BIAS];

  always_comb begin
    // every field gets a value on every path
    state_next.bits.ref_sel = state_reg.bits.ref_sel;
    state_next.bits.temp = state_reg.bits.temp;
    state_next.bits.bias = state_reg.bits.bias;
    state_next.rdata = state_reg.rdata;
    state_next.ana.ref_source_supply = state_reg.ana.ref_source_supply;
    state_next.ana.bias_on = state_reg.ana.bias_on;
    state_next.ana.temp_on = state_reg.ana.temp_on;
    state_next.ana.temp_out_en = state_reg.ana.temp_out_en;
    force_vec = 3'h0;
    bias_forced = 1'b0;
    bias_eff = 1'b0;

    // source select: a write replaces it, otherwise it holds
    if (wr_hit) begin
      state_next.bits.ref_sel = ref_sel_wval;
    end else begin
      state_next.bits.ref_sel = state_reg.bits.ref_sel;
    end

    // sensor enable
    if (wr_hit) begin
      state_next.bits.temp = temp_wval;
    end else begin
      state_next.bits.temp = state_reg.bits.temp;
    end

    // stored bias bit stays as software left it, even while forced
    if (wr_hit) begin
      state_next.bits.bias = bias_wval;
    end else begin
      state_next.bits.bias = state_reg.bits.bias;
    end

    // force uses the sensor enable about to be stored, which is the bus value on a write hit
    force_vec[0] = adc_on_sync;
    force_vec[1] = osc_on_sync;
    force_vec[2] = state_next.bits.temp;
    bias_forced = |force_vec;

    // stored bit kept apart so it reads back once the force drops
    if (bias_forced) begin
      bias_eff = 1'b1;
    end else begin
      bias_eff = state_next.bits.bias;
    end

    // reference routing toward the analog switch
    if (state_next.bits.ref_sel == VRC_SRC_SUPPLY) begin
      state_next.ana.ref_source_supply = 1'b1;
    end else begin
      state_next.ana.ref_source_supply = 1'b0;
    end

    // bias generator power
    state_next.ana.bias_on = bias_eff;

    // sensor power follows its enable bit
    if (state_next.bits.temp) begin
      state_next.ana.temp_on = 1'b1;
    end else begin
      state_next.ana.temp_on = 1'b0;
    end

    // sensor output released (high impedance) whenever it is powered down
    if (state_next.bits.temp) begin
      state_next.ana.temp_out_en = 1'b1;
    end else begin
      state_next.ana.temp_out_en = 1'b0;
    end

    // readback image; registered so the bus sees a clean flop output
    state_next.rdata = VRC_RESET;
    for (int i = 0; i < $bits(state_next.rdata); i++) begin
      if (i == VRC_BIT_REF_SEL) begin
        state_next.rdata[i] = state_next.bits.ref_sel;
      end else if (i == VRC_BIT_TEMP) begin
        state_next.rdata[i] = state_next.bits.temp;
      end else if (i == VRC_BIT_BIAS) begin
        // bias reads the forced value, not the stored one
        state_next.rdata[i] = bias_eff;
      end else begin
        // unused positions read zero, so writes to them vanish
        state_next.rdata[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // all defined bits reset to zero
      state_reg.bits.ref_sel <= VRC_RESET[VRC_BIT_REF_SEL];
      state_reg.bits.temp <= VRC_RESET[VRC_BIT_TEMP];
      state_reg.bits.bias <= VRC_RESET[VRC_BIT_BIAS];
      // image matches the reset value of the register
      state_reg.rdata <= VRC_RESET;
      // analog side powered down and on the external pin during reset
      state_reg.ana.ref_source_supply <= 1'b0;
      state_reg.ana.bias_on <= 1'b0;
      state_reg.ana.temp_on <= 1'b0;
      state_reg.ana.temp_out_en <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // read data is a registered copy, valid at any address
  assign sfr_rdata = state_reg.rdata;
  // hit marks the address as mapped; the host gates read data with it
  assign sfr_hit = sel;
  // analog controls come straight from flops, so no glitches reach them
  assign analog = state_reg.ana;
endmodule
`default_nettype wire

/* File: rtl/vrc_sync.sv */
// module: two-flop synchroniser for a bank of level inputs
`timescale 1ns/10ps
`default_nettype none
module vrc_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } vrc_sync_state_t;

  vrc_sync_state_t state_reg;
  vrc_sync_state_t state_next;

  always_comb begin
    state_next.s1 = d;
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.s2;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// testbench for reference control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vrc_pkg::*;
  logic clk = 0, nrst = 0, adc_enable = 0, osc_enable = 0;
  vrc_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  vrc_analog_t analog;
  int mismatches = 0, checks_done = 0;
  vrc_reference_control dut (.clk, .nrst, .sfr_req, .sfr_rdata, .sfr_hit, .adc_enable,
    .osc_enable, .analog);
  initial begin
    forever #4 clk = ~clk;
  end
  // foreign addresses standing in for the port setup registers; values arbitrary
  localparam logic [7:0] PORT0_INPUT_MODE_ADDR = 8'hF1;
  localparam logic [7:0] PORT0_CROSSBAR_SKIP_ADDR = 8'hD4;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // wr stays high so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk) #1;
  endtask
  task automatic idle(input int n);
    sfr_req.wr = 0;
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic t_regs;
    chk(sfr_rdata, 8'h00);
    wr(VRC_ADDR, 8'hFF);
    wr(8'hC5, 8'h00);
    chk({analog, sfr_rdata[3:0]}, 8'hFE);
    idle(1);
    chk(sfr_rdata, 8'h0E);
    wr(VRC_ADDR, 8'h08);
    chk({analog, sfr_rdata}, 12'h808);
    wr(VRC_ADDR, 8'h00);
    chk({analog, sfr_rdata}, 12'h000);
    idle(1);
  endtask
  task automatic t_bias;
    adc_enable = 1;
    idle(3);
    chk({analog, sfr_rdata}, 12'h402);
    adc_enable = 0;
    osc_enable = 1;
    idle(3);
    chk(sfr_rdata, 8'h02);
    osc_enable = 0;
    wr(VRC_ADDR, 8'h02);
    idle(4);
    chk({analog, sfr_rdata}, 12'h402);
    wr(VRC_ADDR, 8'h00);
    idle(1);
    chk(sfr_rdata, 8'h00);
  endtask
  // external reference: software sets up the pin elsewhere, we must not react
  task automatic t_port;
    wr(VRC_ADDR, 8'h00);
    chk(sfr_hit, 1'b1);
    wr(PORT0_INPUT_MODE_ADDR, 8'hFE);
    chk(sfr_hit, 1'b0);
    wr(PORT0_CROSSBAR_SKIP_ADDR, 8'hFF);
    chk({analog, sfr_rdata}, 12'h000);
    idle(1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1;
    t_regs;
    t_bias;
    t_port;
    stop_test;
  end
endmodule
`default_nettype wire

/* File: verif/vrc_chk.sv */
// checker for reference control
`timescale 1ns/10ps
`default_nettype none
module vrc_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire vrc_pkg::vrc_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic adc_enable,
  input wire logic osc_enable,
  input wire vrc_pkg::vrc_analog_t analog
);
  import vrc_pkg::*;
  wire logic w = sfr_req.wr && sfr_req.addr == VRC_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SRC: assert property (w |=> analog.ref_source_supply == $past(sfr_req.wdata[VRC_BIT_REF_SEL]))
    else $error("src");
  AST_FRC: assert property ((adc_enable || osc_enable)[*4] |-> analog.bias_on && sfr_rdata[VRC_BIT_BIAS])
    else $error("frc");
  AST_KEEP: assert property (w && sfr_req.wdata[VRC_BIT_BIAS] |=> analog.bias_on)
    else $error("keep");
  AST_TEMP: assert property (w |=> analog.temp_on == $past(sfr_req.wdata[VRC_BIT_TEMP]))
    else $error("temp");
  AST_HIZ: assert property (w && !sfr_req.wdata[VRC_BIT_TEMP] |=> !analog.temp_out_en)
    else $error("hiz");
  AST_RSV: assert property (sfr_rdata[7:4] == 4'h0 && !sfr_rdata[0])
    else $error("rsv");
endmodule
bind vrc_reference_control vrc_chk u_chk (.clk, .nrst, .sfr_req, .sfr_rdata, .adc_enable,
  .osc_enable, .analog);
`default_nettype wire
